// file: rtl/sbmu_pkg.sv
// Constants, types and helpers shared by the single-bit manipulation unit
package sbmu_pkg;

	// Opcodes of the three instruction groups
	localparam logic [7:0] OPC_BIT_INVERT   = 8'h57;
	localparam logic [7:0] OPC_BIT_CLR_SET  = 8'h77;
	localparam logic [7:0] OPC_SINGLE_OR    = 8'h07;

	// Instruction lengths in bytes and execution time in cycles
	localparam logic [1:0] BYTES_SHORT      = 2'h2;
	localparam logic [1:0] BYTES_LONG       = 2'h3;
	localparam logic [2:0] CYC_SHORT        = 3'h4;
	localparam logic [2:0] CYC_LONG         = 3'h6;

	// Register address of the condition flags and base of the working registers
	localparam logic [7:0] FLAGS_ADDR       = 8'hD5;
	localparam logic [7:0] WORK_BASE        = 8'hC0;

	// Word indices on the bus; byte address is four times the index
	localparam logic [9:0] IDX_FLAGS        = 10'h0D5;
	localparam logic [9:0] IDX_INSTR        = 10'h100;
	localparam logic [9:0] IDX_CMD          = 10'h101;
	localparam logic [9:0] IDX_STATUS       = 10'h102;

	// Flag bit positions inside the condition flags register
	localparam int         FLAG_C_BIT       = 7;
	localparam int         FLAG_Z_BIT       = 6;
	localparam int         FLAG_S_BIT       = 5;
	localparam int         FLAG_V_BIT       = 4;
	localparam logic [7:0] FLAG_ZS_MASK     = 8'h60;

	// Values after reset
	localparam logic [7:0]  FLAGS_RST       = 8'h00;
	localparam logic [7:0]  RF_RST          = 8'h00;
	localparam logic [23:0] INSTR_RST       = 24'h00_0000;

	// Decoded operation
	typedef enum logic [2:0] {
		OP_NONE,
		OP_INVERT,
		OP_CLEAR,
		OP_SET,
		OP_OR_TO_LSB,
		OP_OR_FROM_LSB
	} sbmu_op_t;

	// One-hot mask of a bit position
	function automatic logic [7:0] sbmu_bit_mask(input logic [2:0] pos);
		return 8'h01 << pos;
	endfunction

endpackage

// file: rtl/sbmu_decode.sv
// Decoder of opcode and second byte into operation, fields and operand addresses
`timescale 1ns/1ps
module sbmu_decode
	import sbmu_pkg::*;
(
	input  wire logic [7:0]        opcode,
	input  wire logic [7:0]        byte2,
	input  wire logic [7:0]        byte3,
	output sbmu_pkg::sbmu_op_t     op,
	output logic      [2:0]        bit_pos,
	output logic      [7:0]        dst_addr,
	output logic      [7:0]        src_addr,
	output logic      [1:0]        nbytes,
	output logic      [2:0]        ncycles,
	output logic                   legal
);
	import sbmu_pkg::*;

	logic [3:0] reg_nib;   // Four-bit register field
	logic       lsb_sel;   // Form selector
	logic [7:0] work_addr; // Working register as full address

	// Second byte split into its three fields
	assign reg_nib = byte2[7:4];
	assign bit_pos = byte2[3:1];
	assign lsb_sel = byte2[0];

	// Complement only exists with selector 0; the other code is refused
	assign op = (opcode == OPC_BIT_INVERT && !lsb_sel) ? OP_INVERT :
		(opcode == OPC_BIT_CLR_SET) ? (lsb_sel ? OP_SET : OP_CLEAR) :
		(opcode == OPC_SINGLE_OR) ? (lsb_sel ? OP_OR_FROM_LSB : OP_OR_TO_LSB) :
		OP_NONE;

	assign legal = (op != OP_NONE);
	assign work_addr = WORK_BASE | {4'h0, reg_nib};

	// Only the second OR form puts the full-register operand on the destination
	assign dst_addr = (op == OP_OR_FROM_LSB) ? byte3 : work_addr;
	assign src_addr = (op == OP_OR_TO_LSB) ? byte3 : work_addr;

	// Length and time per group
	assign nbytes = (op == OP_OR_TO_LSB || op == OP_OR_FROM_LSB) ? BYTES_LONG :
		BYTES_SHORT;
	assign ncycles = (op == OP_OR_TO_LSB || op == OP_OR_FROM_LSB) ? CYC_LONG :
		CYC_SHORT;
endmodule

// file: rtl/sbmu_bitalu.sv
// Bit datapath: new destination byte and new condition flags
`timescale 1ns/1ps
module sbmu_bitalu
	import sbmu_pkg::*;
(
	input  sbmu_pkg::sbmu_op_t     op,
	input  wire logic [2:0]        bit_pos,
	input  wire logic [7:0]        dst_val,
	input  wire logic [7:0]        src_val,
	input  wire logic [7:0]        flags_in,
	output logic      [7:0]        result,
	output logic      [7:0]        flags_out,
	output logic                   flags_wr
);
	import sbmu_pkg::*;

	logic [7:0] mask;     // Selected bit
	logic       src_bit;  // Selected source bit
	logic       zero;     // Result byte is zero

	assign mask = sbmu_bit_mask(bit_pos);
	assign src_bit = |(src_val & mask);

	// Each form touches exactly one destination bit
	assign result = (op == OP_INVERT) ? (dst_val ^ mask) :
		(op == OP_CLEAR) ? (dst_val & ~mask) :
		(op == OP_SET) ? (dst_val | mask) :
		(op == OP_OR_TO_LSB) ? (dst_val | {7'h00, src_bit}) :
		(op == OP_OR_FROM_LSB) ? (dst_val | (src_val[0] ? mask : 8'h00)) :
		dst_val;

	assign zero = (result == 8'h00);

	// Clear and set leave the flags alone, so they never write them
	assign flags_wr = (op == OP_INVERT || op == OP_OR_TO_LSB ||
		op == OP_OR_FROM_LSB);

	// Zero follows the byte, sign cleared, overflow and the rest kept
	assign flags_out = (flags_in & ~FLAG_ZS_MASK) |
		(zero ? (8'h01 << FLAG_Z_BIT) : 8'h00);
endmodule

// file: rtl/sbmu_top.sv
// APB-reached single-bit manipulation unit with its register file
// Operation
// - Complement flips one bit, opcode 57, 2 bytes, 4 cycles
// - Complement: zero from result, sign cleared, others kept
// - Second byte: register, bit position, selector
// - Clear zeroes one bit, opcode 77, 2 bytes, 4 cycles
// - Set forces one bit, 2 bytes, 4 cycles
// - Clear and set keep all flags
// - Opcode 77: selector 0 clear, 1 set
// - Bit OR changes only one destination bit
// - Bit OR opcode 07, 3 bytes, 6 cycles, two forms
// - Bit OR: zero from result, sign cleared
// - Bit OR writes its source only when it is also the destination or the flags byte
// - Zero flag lives in flags register at D5
`timescale 1ns/1ps
module sbmu_top
	import sbmu_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic                   busy,
	output logic                   done
);
	import sbmu_pkg::*;

	typedef enum logic {ST_IDLE, ST_EXEC} sbmu_state_t;

	////////////////////////////////////////////////////////////////////////////
	// Storage
	logic [7:0]  rf_reg [256];      // Register file, flags at D5
	logic [23:0] instr_reg;         // Instruction bytes, opcode low
	logic [23:0] instr_next;
	logic [2:0]  left_reg;          // Cycles left in execution
	logic [2:0]  left_next;
	logic        done_reg;          // Last instruction completed
	logic        done_next;
	logic        illegal_reg;       // Last start was refused
	logic        illegal_next;
	logic [31:0] prdata_reg;        // Read data captured at setup
	sbmu_state_t state_reg;
	sbmu_state_t state_next;

	////////////////////////////////////////////////////////////////////////////
	// Bus decode
	logic [9:0]  idx;               // Word index
	logic        aligned;
	logic        hit_rf;
	logic        hit_instr;
	logic        hit_cmd;
	logic        hit_status;
	logic        acc;               // Access phase
	logic        wr;
	logic        bus_err;
	logic        rf_wr;
	logic        instr_wr;
	logic        start;             // Command write with go bit
	logic [31:0] status_word;
	logic [31:0] rd_mux;

	assign idx = paddr[11:2];
	assign aligned = (paddr[1:0] == 2'b00);
	assign hit_rf = aligned && (idx[9:8] == 2'b00);
	assign hit_instr = aligned && (idx == IDX_INSTR);
	assign hit_cmd = aligned && (idx == IDX_CMD);
	assign hit_status = aligned && (idx == IDX_STATUS);
	assign acc = psel && penable;
	assign wr = acc && pwrite;

	// Writes that could race the datapath are refused while it runs
	assign bus_err = !(hit_rf || hit_instr || hit_cmd || hit_status) ||
		(pwrite && hit_status) ||
		(pwrite && busy && (hit_rf || hit_instr || hit_cmd));

	assign pready = 1'b1;
	assign pslverr = acc && bus_err;
	assign rf_wr = wr && hit_rf && !bus_err;
	assign instr_wr = wr && hit_instr && !bus_err;
	assign start = wr && hit_cmd && !bus_err && pwdata[0];

	////////////////////////////////////////////////////////////////////////////
	// Decode and datapath
	sbmu_op_t    dec_op;
	logic [2:0]  dec_bit;
	logic [7:0]  dec_dst;
	logic [7:0]  dec_src;
	logic [1:0]  dec_bytes;
	logic [2:0]  dec_cycles;
	logic        dec_legal;
	logic [7:0]  alu_result;
	logic [7:0]  alu_flags;
	logic        alu_flags_wr;
	logic        wb;                // Final execution cycle

	sbmu_decode u_decode (
		.opcode   (instr_reg[7:0]),
		.byte2    (instr_reg[15:8]),
		.byte3    (instr_reg[23:16]),
		.op       (dec_op),
		.bit_pos  (dec_bit),
		.dst_addr (dec_dst),
		.src_addr (dec_src),
		.nbytes   (dec_bytes),
		.ncycles  (dec_cycles),
		.legal    (dec_legal)
	);

	// Operands read at writeback; bus writes cannot change them meanwhile
	sbmu_bitalu u_alu (
		.op        (dec_op),
		.bit_pos   (dec_bit),
		.dst_val   (rf_reg[dec_dst]),
		.src_val   (rf_reg[dec_src]),
		.flags_in  (rf_reg[FLAGS_ADDR]),
		.result    (alu_result),
		.flags_out (alu_flags),
		.flags_wr  (alu_flags_wr)
	);

	////////////////////////////////////////////////////////////////////////////
	// Sequencer
	assign busy = (state_reg == ST_EXEC);
	assign done = done_reg;
	assign wb = busy && (left_reg == 3'h1);

	// Idle until a legal start, then count the instruction's cycles
	assign state_next = (start && dec_legal) ? ST_EXEC : wb ? ST_IDLE : state_reg;
	assign left_next = (start && dec_legal) ? 3'(dec_cycles - 3'h1) :
		busy ? 3'(left_reg - 3'h1) : left_reg;
	// Completion wins over a clear in the same cycle
	assign done_next = wb ? 1'b1 : start ? 1'b0 : done_reg;
	assign illegal_next = start ? !dec_legal : illegal_reg;
	assign instr_next = instr_wr ? pwdata[23:0] : instr_reg;

	// Status layout: busy, done, illegal, bytes at 5:4, cycles at 10:8
	assign status_word = {21'h00_0000, dec_cycles, 2'h0, dec_bytes, 1'h0,
		illegal_reg, done_reg, busy};

	assign rd_mux = hit_rf ? {24'h00_0000, rf_reg[idx[7:0]]} :
		hit_instr ? {8'h00, instr_reg} :
		hit_status ? status_word : 32'h0000_0000;
	assign prdata = prdata_reg;

	// Control registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg   <= ST_IDLE;
			left_reg    <= 3'h0;
			done_reg    <= 1'b0;
			illegal_reg <= 1'b0;
			instr_reg   <= INSTR_RST;
		end
		else
		begin
			state_reg   <= state_next;
			left_reg    <= left_next;
			done_reg    <= done_next;
			illegal_reg <= illegal_next;
			instr_reg   <= instr_next;
		end
	end

	// Read data frozen in the setup cycle so it holds through access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_reg <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata_reg <= rd_mux;
	end

	// Register file; flags written last so they win when dst is D5
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < 256; i++)
				rf_reg[i] <= RF_RST;
			rf_reg[FLAGS_ADDR] <= FLAGS_RST;
		end
		else
		begin
			if (rf_wr)
				rf_reg[idx[7:0]] <= pwdata[7:0];
			if (wb)
				rf_reg[dec_dst] <= alu_result;
			if (wb && alu_flags_wr)
				rf_reg[FLAGS_ADDR] <= alu_flags;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	logic [7:0] mask_chk;
	assign mask_chk = sbmu_bit_mask(dec_bit);

	invert_result_a: assert property (@(posedge pclk) disable iff (!presetn)
		wb && dec_op == OP_INVERT |=> rf_reg[$past(dec_dst)] ==
		($past(rf_reg[dec_dst]) ^ $past(mask_chk)) || $past(dec_dst) == FLAGS_ADDR)
		else $error("complement changed the wrong bits");

	invert_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
		wb && dec_op == OP_INVERT |=> rf_reg[FLAGS_ADDR][FLAG_Z_BIT] ==
		($past(alu_result) == 8'h00) && !rf_reg[FLAGS_ADDR][FLAG_S_BIT] &&
		rf_reg[FLAGS_ADDR][FLAG_C_BIT] == $past(rf_reg[FLAGS_ADDR][FLAG_C_BIT]))
		else $error("complement flags wrong");

	field_split_a: assert property (@(posedge pclk) disable iff (!presetn)
		dec_legal && dec_op != OP_OR_FROM_LSB |->
		dec_dst == (WORK_BASE | {4'h0, instr_reg[15:12]}) && dec_bit == instr_reg[11:9])
		else $error("second byte fields misdecoded");

	clear_result_a: assert property (@(posedge pclk) disable iff (!presetn)
		wb && dec_op == OP_CLEAR |-> alu_result == (rf_reg[dec_dst] & ~mask_chk))
		else $error("clear result wrong");

	set_result_a: assert property (@(posedge pclk) disable iff (!presetn)
		wb && dec_op == OP_SET |-> alu_result == (rf_reg[dec_dst] | mask_chk))
		else $error("set result wrong");

	clrset_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
		wb && (dec_op == OP_CLEAR || dec_op == OP_SET) && dec_dst != FLAGS_ADDR
		|=> $stable(rf_reg[FLAGS_ADDR]))
		else $error("clear or set touched flags");

	clrset_select_a: assert property (@(posedge pclk) disable iff (!presetn)
		instr_reg[7:0] == OPC_BIT_CLR_SET |->
		dec_op == (instr_reg[8] ? OP_SET : OP_CLEAR))
		else $error("selector misdecoded");

	or_one_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
		wb && dec_op == OP_OR_TO_LSB |-> ((alu_result ^ rf_reg[dec_dst]) & 8'hFE) == 8'h00)
		else $error("bit OR changed other bits");

	or_timing_a: assert property (@(posedge pclk) disable iff (!presetn)
		start && instr_reg[7:0] == OPC_SINGLE_OR |-> !wb ##1 (busy && !wb) [*4] ##1 wb)
		else $error("bit OR not six cycles");

	short_timing_a: assert property (@(posedge pclk) disable iff (!presetn)
		start && dec_legal && dec_cycles == CYC_SHORT |-> ##3 wb)
		else $error("short instruction not four cycles");

	or_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
		wb && dec_op == OP_OR_FROM_LSB && dec_dst != FLAGS_ADDR |=>
		rf_reg[FLAGS_ADDR][FLAG_Z_BIT] == ($past(alu_result) == 8'h00) &&
		!rf_reg[FLAGS_ADDR][FLAG_S_BIT])
		else $error("bit OR flags wrong");

	or_source_a: assert property (@(posedge pclk) disable iff (!presetn)
		wb && (dec_op == OP_OR_TO_LSB || dec_op == OP_OR_FROM_LSB) &&
		dec_src != dec_dst && dec_src != FLAGS_ADDR |=>
		rf_reg[$past(dec_src)] == $past(rf_reg[dec_src]))
		else $error("bit OR wrote its source");

	overflow_kept_a: assert property (@(posedge pclk) disable iff (!presetn)
		wb && dec_dst != FLAGS_ADDR |=> $stable(rf_reg[FLAGS_ADDR][FLAG_V_BIT]))
		else $error("overflow flag changed");

	// Complement keeps carry, overflow, decimal-adjust and half-carry
	invert_kept_a: assert property (@(posedge pclk) disable iff (!presetn)
		wb && dec_op == OP_INVERT |=>
		(rf_reg[FLAGS_ADDR] & ~FLAG_ZS_MASK) == ($past(rf_reg[FLAGS_ADDR]) & ~FLAG_ZS_MASK))
		else $error("complement disturbed kept flags");

	// First OR form: zero follows the byte, sign cleared, the rest kept
	or_lsb_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
		wb && dec_op == OP_OR_TO_LSB |=>
		rf_reg[FLAGS_ADDR][FLAG_Z_BIT] == ($past(alu_result) == 8'h00) &&
		!rf_reg[FLAGS_ADDR][FLAG_S_BIT] &&
		(rf_reg[FLAGS_ADDR] & ~FLAG_ZS_MASK) == ($past(rf_reg[FLAGS_ADDR]) & ~FLAG_ZS_MASK))
		else $error("first bit OR form flags wrong");

	// Second OR form may move only the addressed destination bit
	or_from_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
		wb && dec_op == OP_OR_FROM_LSB |->
		((alu_result ^ rf_reg[dec_dst]) & ~mask_chk) == 8'h00)
		else $error("second bit OR form changed other bits");

	// Flag updates land in the condition flags byte
	flags_home_a: assert property (@(posedge pclk) disable iff (!presetn)
		wb && alu_flags_wr |=> rf_reg[FLAGS_ADDR] == $past(alu_flags))
		else $error("flags not stored in the flags byte");

	// Opcode 77 runs four cycles, judged by opcode rather than decoded count
	clrset_timing_a: assert property (@(posedge pclk) disable iff (!presetn)
		start && instr_reg[7:0] == OPC_BIT_CLR_SET |->
		!wb ##1 (busy && !wb) [*2] ##1 wb ##1 !busy)
		else $error("clear or set not four cycles");

	// Complement runs four cycles and then frees the sequencer
	invert_timing_a: assert property (@(posedge pclk) disable iff (!presetn)
		start && instr_reg[7:0] == OPC_BIT_INVERT && !instr_reg[8] |->
		!wb ##1 (busy && !wb) [*2] ##1 wb ##1 !busy)
		else $error("complement not four cycles");
endmodule

// file: dv/sbmu_top_bench.sv
// Self-checking APB bench of the single-bit manipulation unit
`timescale 1ns/1ps
module sbmu_top_bench;
	import sbmu_pkg::*;

	logic        pclk;      // Core clock, 25 MHz
	logic        presetn;   // Async reset, active low
	logic        psel;      // APB select
	logic        penable;   // APB access phase
	logic        pwrite;    // APB direction
	logic [11:0] paddr;     // APB byte address
	logic [31:0] pwdata;    // APB write data
	logic [31:0] prdata;    // APB read data
	logic        pready;    // APB ready
	logic        pslverr;   // APB error
	logic        busy;      // Instruction executing
	logic        done;      // Sticky completion
	int          bad_count; // Mismatches seen
	int          checked;   // Comparisons made
	logic [31:0] rd;        // Last read word
	logic        err;       // Last error response
	int          n;         // Busy cycle count

	// Clock, 40 ns period
	initial pclk = 1'b0;
	always #20 pclk = ~pclk;

	sbmu_top u_dut (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.busy    (busy),
		.done    (done)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Verdict and comparison helpers
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Byte address of a register-file byte and of a bus word index
	function automatic logic [11:0] ra(input logic [7:0] r);
		return {2'b00, r, 2'b00};
	endfunction
	function automatic logic [11:0] ia(input logic [9:0] i);
		return {i, 2'b00};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// APB master: setup, access, hold until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && k < 20)
		begin
			@(posedge pclk);
			k++;
		end
		if (k >= 20)
		begin
			bad_count++;
			conclude();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Write with an expected error response
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
		apb(1'b1, a, d);
		chk("pslverr", {31'h0, e}, {31'h0, err});
	endtask

	// Read and compare under a mask
	task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp,
		input string what);
		apb(1'b0, a, 32'h0000_0000);
		chk(what, exp, rd & m);
	endtask

	// Bounded wait for the end of execution, counting busy cycles
	task automatic wait_idle();
		n = 0;
		#1;
		while (busy === 1'b1 && n < 50)
		begin
			n++;
			@(posedge pclk);
			#1;
		end
		if (n >= 50)
		begin
			bad_count++;
			conclude();
		end
	endtask

	// Load, check decoded length and time, start, check busy span and done
	task automatic run(input logic [23:0] ins, input logic [1:0] nb, input logic [2:0] nc);
		wr(ia(IDX_INSTR), {8'h00, ins}, 1'b0);
		rc(ia(IDX_STATUS), 32'h0000_0734, {21'h0, nc, 2'b00, nb, 4'h0}, "length and time");
		wr(ia(IDX_CMD), 32'h0000_0001, 1'b0);
		wait_idle();
		chk("busy cycles", {29'h0, nc} - 32'h0000_0001, n);
		chk("done pin", 32'h0000_0001, {31'h0, done});
		rc(ia(IDX_STATUS), 32'h0000_0007, 32'h0000_0002, "done status");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		bad_count = 0;
		checked   = 0;
		presetn   = 1'b0;
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = 12'h000;
		pwdata    = 32'h0000_0000;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rc(ia(IDX_FLAGS), 32'hFFFF_FFFF, 32'h0000_0000, "flags reset");
		// Complement r1 bit 1 with every flag set: only Z and S may move
		wr(ia(IDX_FLAGS), 32'h0000_00FC, 1'b0);
		wr(ra(WORK_BASE + 8'h01), 32'h0000_0007, 1'b0);
		run(24'h00_1257, BYTES_SHORT, CYC_SHORT);
		rc(ra(WORK_BASE + 8'h01), 32'hFFFF_FFFF, 32'h0000_0005, "r1 complement");
		rc(ia(IDX_FLAGS), 32'h0000_00FF, 32'h0000_009C, "flags complement");
		// Complement to a zero byte sets Z
		wr(ra(WORK_BASE + 8'h02), 32'h0000_0002, 1'b0);
		run(24'h00_2257, BYTES_SHORT, CYC_SHORT);
		rc(ra(WORK_BASE + 8'h02), 32'h0000_00FF, 32'h0000_0000, "r2 complement");
		rc(ia(IDX_FLAGS), 32'h0000_00FF, 32'h0000_00DC, "flags zero");
		// Clear bit 0 then set bit 7 of r1, flags untouched
		run(24'h00_1077, BYTES_SHORT, CYC_SHORT);
		rc(ra(WORK_BASE + 8'h01), 32'h0000_00FF, 32'h0000_0004, "r1 clear");
		run(24'h00_1F77, BYTES_SHORT, CYC_SHORT);
		rc(ra(WORK_BASE + 8'h01), 32'h0000_00FF, 32'h0000_0084, "r1 set");
		rc(ia(IDX_FLAGS), 32'h0000_00FF, 32'h0000_00DC, "flags clear set");
		// OR into r1 bit 0 from register 01 bit 1
		wr(ra(WORK_BASE + 8'h01), 32'h0000_0006, 1'b0);
		wr(ra(8'h01), 32'h0000_0003, 1'b0);
		run(24'h01_1207, BYTES_LONG, CYC_LONG);
		rc(ra(WORK_BASE + 8'h01), 32'h0000_00FF, 32'h0000_0007, "r1 or");
		rc(ra(8'h01), 32'h0000_00FF, 32'h0000_0003, "source kept");
		rc(ia(IDX_FLAGS), 32'h0000_00FF, 32'h0000_009C, "flags or");
		// OR into register 01 bit 2 from r1 bit 0, Z and S preset
		wr(ia(IDX_FLAGS), 32'h0000_0060, 1'b0);
		run(24'h01_1507, BYTES_LONG, CYC_LONG);
		rc(ra(8'h01), 32'h0000_00FF, 32'h0000_0007, "reg01 or");
		rc(ra(WORK_BASE + 8'h01), 32'h0000_00FF, 32'h0000_0007, "r1 kept");
		rc(ia(IDX_FLAGS), 32'h0000_00FF, 32'h0000_0000, "flags or nonzero");
		// OR of two zero operands sets Z
		run(24'h04_3207, BYTES_LONG, CYC_LONG);
		rc(ia(IDX_FLAGS), 32'h0000_00FF, 32'h0000_0040, "flags or zero");
		// Refusals: unmapped word, read-only status, start while busy
		wr(ia(10'h103), 32'h0000_0001, 1'b1);
		wr(ia(IDX_STATUS), 32'h0000_0001, 1'b1);
		wr(ia(IDX_INSTR), 32'h0000_1257, 1'b0);
		wr(ia(IDX_CMD), 32'h0000_0001, 1'b0);
		wr(ia(IDX_CMD), 32'h0000_0001, 1'b1);
		wait_idle();
		rc(ra(WORK_BASE + 8'h01), 32'h0000_00FF, 32'h0000_0005, "single flip");
		// Complement with selector 1 is not decoded; done drops, nothing runs
		wr(ia(IDX_INSTR), 32'h0000_1357, 1'b0);
		rc(ia(IDX_STATUS), 32'h0000_0007, 32'h0000_0002, "illegal before start");
		wr(ia(IDX_CMD), 32'h0000_0001, 1'b0);
		wait_idle();
		chk("done pin", 32'h0000_0000, {31'h0, done});
		rc(ia(IDX_STATUS), 32'h0000_0007, 32'h0000_0004, "illegal status");
		rc(ra(WORK_BASE + 8'h01), 32'h0000_00FF, 32'h0000_0005, "r1 untouched");
		conclude();
	end

endmodule
